// >>> common/gpio_irq_pkg.sv
package gpio_irq_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] RISING_IRQ_MASK_SET_ADDR = 8'h0e;
  localparam logic [7:0] RISING_IRQ_MASK_CLEAR_ADDR = 8'h0f;
  localparam logic [7:0] PIN_DIRECTION_SET_ADDR = 8'h14;
  localparam logic [7:0] PIN_DIRECTION_CLEAR_ADDR = 8'h15;
  localparam logic [7:0] PIN_LEVEL_SET_ADDR = 8'h16;
  localparam logic [7:0] PIN_LEVEL_CLEAR_ADDR = 8'h17;
  localparam logic [7:0] PIN_INPUT_STATE_ADDR = 8'h18;
  localparam logic [7:0] PIN_IRQ_LATCH_SET_ADDR = 8'h1a;
  localparam logic [7:0] PIN_IRQ_LATCH_CLEAR_ADDR = 8'h1b;
  localparam logic [7:0] PIN_FALL_MASK_SET_ADDR = 8'h1c;
  localparam logic [7:0] PIN_FALL_MASK_CLEAR_ADDR = 8'h1d;
  localparam logic [7:0] PIN_RISE_MASK_SET_ADDR = 8'h1e;
  localparam logic [7:0] PIN_RISE_MASK_CLEAR_ADDR = 8'h1f;

  // ==========================================================
  // Widths and reset values
  localparam int PIN_COUNT = 3;
  localparam int SRC_COUNT = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] PIN_RESET = 3'h0;

  // ==========================================================
  // Status source bit positions
  localparam int SRC_BUS_VALID = 0;
  localparam int SRC_SESSION_VALID = 1;
  localparam int SRC_PLUS_LINE_HIGH = 2;
  localparam int SRC_IDENT_GROUNDED = 3;
  localparam int SRC_MINUS_LINE_HIGH = 4;
  localparam int SRC_IDENT_OPEN = 5;
  localparam int SRC_SESSION_END = 6;
  localparam int SRC_CARKIT_PULSE_FLAG = 7;
endpackage

// >>> common/setclr_if.sv
// Set/clear write strobes travelling from the decoder to each register
interface setclr_if;
  logic set_we;
  logic clr_we;
  logic [7:0] wdata;
  logic [7:0] value;
  modport ctrl (output set_we, output clr_we, output wdata, input value);
  modport store (input set_we, input clr_we, input wdata, output value);
endinterface

// >>> logic/setclr_reg.sv
// One set/clear register; hardware set wins over software clear
module setclr_reg
  import gpio_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Bus side
  setclr_if.store bus,
  // Hardware set events
  input wire logic [7:0] hw_set_in
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  // ==========================================================
  // Update: ones set or clear, zeros leave bits alone
  always_comb begin
    value_next = value_reg;
    if (bus.clr_we) begin
      value_next = value_next & ~bus.wdata;
    end
    if (bus.set_we) begin
      value_next = value_next | bus.wdata;
    end
    value_next = value_next | hw_set_in;  // Event in clear cycle not lost
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      value_reg <= REG_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  assign bus.value = value_reg;
endmodule

// >>> logic/gpio_port.sv
module gpio_port
  import gpio_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  // Status sources, bit order fixed
  input wire logic [7:0] status_src_in,
  output logic [7:0] status_rise_event_out,
  // General-purpose pins
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_out,
  // Any pin latch bit set
  output logic pin_irq_pending_out
);
  // Bank slots; each slot holds one set/clear pair
  localparam int NREG = 6;
  localparam int R_RMASK = 0;
  localparam int R_DIR = 1;
  localparam int R_LVL = 2;
  localparam int R_LATCH = 3;
  localparam int R_FALL = 4;
  localparam int R_RISE = 5;

  // One interface per register pair
  setclr_if regs [NREG] ();

  logic [7:0] set_addr [NREG];
  logic [7:0] status_prev_reg;
  logic [2:0] pin_prev_reg;
  logic [7:0] pin_event;
  logic [7:0] rdata_next;
  logic hit_next;
  // Plain copies of the bank outputs; an interface array takes fixed indexes only
  logic [7:0] reg_value [NREG];
  logic [7:0] rise_mask_value;
  logic [7:0] dir_value;
  logic [7:0] level_value;
  logic [7:0] latch_value;
  logic [7:0] pin_fall_mask_value;
  logic [7:0] pin_rise_mask_value;
  // Raw pin transitions before masking
  logic [7:0] pin_rise_all;
  logic [7:0] pin_fall_all;

  // ==========================================================
  // Address of the set half; clear half sits one above
  // Every set half sits on an even address
  assign set_addr[R_RMASK] = RISING_IRQ_MASK_SET_ADDR;
  assign set_addr[R_DIR] = PIN_DIRECTION_SET_ADDR;
  assign set_addr[R_LVL] = PIN_LEVEL_SET_ADDR;
  assign set_addr[R_LATCH] = PIN_IRQ_LATCH_SET_ADDR;
  assign set_addr[R_FALL] = PIN_FALL_MASK_SET_ADDR;
  assign set_addr[R_RISE] = PIN_RISE_MASK_SET_ADDR;

  // Widen the three pin bits to a register byte; upper bits read as zero
  function automatic logic [7:0] pad_pins(input logic [2:0] p);
    pad_pins = {5'h00, p};
  endfunction

  // Bits that went from low to high since the last sample
  function automatic logic [7:0] rose_bits(input logic [7:0] now_v, input logic [7:0] was_v);
    rose_bits = now_v & ~was_v;
  endfunction

  // Bits that went from high to low since the last sample
  function automatic logic [7:0] fell_bits(input logic [7:0] now_v, input logic [7:0] was_v);
    fell_bits = ~now_v & was_v;
  endfunction

  // Clear half of every pair sits one address above its set half
  function automatic logic [7:0] clear_of(input logic [7:0] set_a);
    clear_of = set_a + 8'h01;
  endfunction

  // ==========================================================
  // Set/clear register bank
  // set/clear decode
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    assign regs[i].set_we = reg_wr_in && (reg_addr_in == set_addr[i]);
    assign regs[i].clr_we = reg_wr_in && (reg_addr_in == clear_of(set_addr[i]));
    assign regs[i].wdata = reg_wdata_in;
    assign reg_value[i] = regs[i].value;
    // Only the latch takes hardware sets; the others are software-only
    setclr_reg u_reg (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .bus(regs[i]),
      .hw_set_in((i == R_LATCH) ? pin_event : 8'h00)
    );
  end

  // ==========================================================
  // Named views of the bank, one per register pair
  // Bits 7:3 of the pin registers are kept but reach no pin
  assign rise_mask_value = reg_value[R_RMASK];
  assign dir_value = reg_value[R_DIR];
  assign level_value = reg_value[R_LVL];
  assign latch_value = reg_value[R_LATCH];
  assign pin_fall_mask_value = reg_value[R_FALL];
  assign pin_rise_mask_value = reg_value[R_RISE];

  // ==========================================================
  // Previous-sample registers for edge detection
  // A high input at release looks like an edge, but every mask is
  // still clear then, so no event escapes before software opens one
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status_prev_reg <= REG_RESET;
    end else begin
      status_prev_reg <= status_src_in;
    end
  end

  // Pin history kept apart from the status history
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pin_prev_reg <= PIN_RESET;
    end else begin
      pin_prev_reg <= pin_in;
    end
  end

  // ==========================================================
  // Status source rising events; mask bit per source
  // rising mask gating
  // source bit order
  // Pulse lasts one cycle; a source that stays high raises no second event
  assign status_rise_event_out = rose_bits(status_src_in, status_prev_reg) & rise_mask_value;

  // ==========================================================
  // Pin edge events into the sticky latch
  // fall and rise masks
  assign pin_rise_all = rose_bits(pad_pins(pin_in), pad_pins(pin_prev_reg));
  assign pin_fall_all = fell_bits(pad_pins(pin_in), pad_pins(pin_prev_reg));
  // Padding keeps bits 7:3 of the event at zero whatever their mask bits hold
  assign pin_event = (pin_rise_all & pin_rise_mask_value)
                   | (pin_fall_all & pin_fall_mask_value);
  // Pending follows only the three pin bits of the latch
  assign pin_irq_pending_out = |latch_value[2:0];

  // ==========================================================
  // Pin drive: enable from direction, level from output register
  // drive when set
  assign pin_oe_out = dir_value[2:0];
  // drive high when set
  // Level is held while the pin is an input, so turning it around
  // drives the last written value at once
  assign pin_out = level_value[2:0];

  // ==========================================================
  // Read mux; readable at both addresses of a pair
  // Unmapped addresses, the one above the input register too, read zero
  always_comb begin
    rdata_next = 8'h00;
    hit_next = 1'b1;
    case (reg_addr_in)
      RISING_IRQ_MASK_SET_ADDR, RISING_IRQ_MASK_CLEAR_ADDR: begin
        rdata_next = rise_mask_value;
      end
      PIN_DIRECTION_SET_ADDR, PIN_DIRECTION_CLEAR_ADDR: begin
        rdata_next = dir_value;
      end
      PIN_LEVEL_SET_ADDR, PIN_LEVEL_CLEAR_ADDR: begin
        rdata_next = level_value;
      end
      PIN_IRQ_LATCH_SET_ADDR, PIN_IRQ_LATCH_CLEAR_ADDR: begin
        rdata_next = latch_value;
      end
      PIN_FALL_MASK_SET_ADDR, PIN_FALL_MASK_CLEAR_ADDR: begin
        rdata_next = pin_fall_mask_value;
      end
      PIN_RISE_MASK_SET_ADDR, PIN_RISE_MASK_CLEAR_ADDR: begin
        rdata_next = pin_rise_mask_value;
      end
      PIN_INPUT_STATE_ADDR: begin
        rdata_next = pad_pins(pin_in);
      end
      default: begin
        hit_next = 1'b0;
      end
    endcase
  end

  // Read data registered; holds until next read
  // Hit is kept with it so both describe the same read
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= REG_RESET;
      reg_hit_out <= 1'b0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_next;
      reg_hit_out <= hit_next;
    end
  end
endmodule

// >>> test/gpio_pins_model.sv
// ==========================================
// Far-side pin model
module gpio_pins_model (
  // Port drive and outside level
  input logic [2:0] drive_in,
  input logic [2:0] oe_in,
  input logic [2:0] ext_in,
  output logic [2:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule

// >>> test/gpio_port_monitor.sv
// ==========================================
// Port checker
module gpio_port_monitor
  import gpio_irq_pkg::*;
(
  // Watched ports
  input logic clk_in,
  input logic reset_n_in,
  input logic reg_wr_in,
  input logic reg_rd_in,
  input logic [7:0] reg_addr_in,
  input logic [7:0] reg_wdata_in,
  input logic [7:0] reg_rdata_out,
  input logic [7:0] status_src_in,
  input logic [7:0] status_rise_event_out,
  input logic [2:0] pin_in,
  input logic [2:0] pin_out,
  input logic [2:0] pin_oe_out,
  input logic pin_irq_pending_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // One write; bits 7:3 never reach pins
  sequence s_wr(a);
    reg_wr_in && reg_addr_in == a;
  endsequence
  property p_set(a, v);
    s_wr(a) |=> (v & $past(reg_wdata_in[2:0])) == $past(reg_wdata_in[2:0]);
  endproperty
  property p_clr(a, v);
    s_wr(a) |=> (v & $past(reg_wdata_in[2:0])) == 3'h0;
  endproperty
  a_dir_set: assert property (p_set(PIN_DIRECTION_SET_ADDR, pin_oe_out))
    else $error("oe set");
  a_dir_clear: assert property (p_clr(PIN_DIRECTION_CLEAR_ADDR, pin_oe_out))
    else $error("oe clear");
  a_level_set: assert property (p_set(PIN_LEVEL_SET_ADDR, pin_out))
    else $error("level set");
  a_level_clear: assert property (p_clr(PIN_LEVEL_CLEAR_ADDR, pin_out))
    else $error("level clear");
  a_input_read: assert property (reg_rd_in && reg_addr_in == PIN_INPUT_STATE_ADDR
    |=> reg_rdata_out[2:0] == $past(pin_in)) else $error("input read");
  // Edge history is valid only one cycle past reset
  a_rise_cause: assert property ($past(reset_n_in) |->
    (status_rise_event_out & ~(status_src_in & ~$past(status_src_in))) == 8'h00)
    else $error("rise event");
  a_latch_set: assert property (s_wr(PIN_IRQ_LATCH_SET_ADDR) ##0 reg_wdata_in[0]
    |=> pin_irq_pending_out) else $error("latch set");
  a_latch_clear: assert property ($past(reset_n_in) && pin_in == $past(pin_in)
    ##0 s_wr(PIN_IRQ_LATCH_CLEAR_ADDR) ##0 reg_wdata_in[2:0] == 3'h7
    |=> !pin_irq_pending_out) else $error("latch clear");
endmodule
bind gpio_port gpio_port_monitor gpio_port_monitor_inst (.clk_in, .reset_n_in, .reg_wr_in,
  .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .status_src_in,
  .status_rise_event_out, .pin_in, .pin_out, .pin_oe_out, .pin_irq_pending_out);

// >>> test/gpio_and_rising_irq_mask_tb.sv
// ==========================================
// Register, pin and status bench
module gpio_and_rising_irq_mask_tb
  import gpio_irq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, reset_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic reg_hit_out, pin_irq_pending_out;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, status_src_in = 8'h00, s, c;
  logic [7:0] reg_rdata_out, status_rise_event_out, shadow [6];
  logic [7:0] pairs [6] = '{8'h14, 8'h16, 8'h0e, 8'h1c, 8'h1e, 8'h1a};
  logic [2:0] pin_in, pin_out, pin_oe_out, ext = 3'h0;
  int bad_count = 0, n_tests = 0;
  gpio_port gpio_port_inst (.clk_in, .reset_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .reg_hit_out, .status_src_in, .status_rise_event_out,
    .pin_in, .pin_out, .pin_oe_out, .pin_irq_pending_out);
  gpio_pins_model gpio_pins_model_inst (.drive_in(pin_out), .oe_in(pin_oe_out),
    .ext_in(ext), .level_out(pin_in));
  initial forever #2 clk_in = ~clk_in;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobes held one full cycle
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) #1 reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge clk_in) #1 reg_wr_in = 0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk_in) #1 reg_rd_in = 1;
    reg_addr_in = a;
    @(posedge clk_in) #1 reg_rd_in = 0;
  endtask
  // Level on a shared pin wire
  function automatic logic [7:0] lvl(input logic [2:0] oe, o, e);
    return {5'h00, (oe & o) | (~oe & e)};
  endfunction
  task automatic final_report;
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(33728));
    repeat (16) @(posedge clk_in);
    #1 reset_n_in = 1;
    // Pins settle before edge masks open
    foreach (pairs[i]) begin
      s = $urandom;
      c = $urandom;
      wreg(pairs[i], s);
      wreg(pairs[i] + 8'h01, c);
      shadow[i] = s & ~c;
      rreg(pairs[i]);
      chk(reg_rdata_out, shadow[i]);
      chk({7'h00, reg_hit_out}, 8'h01);
      rreg(pairs[i] + 8'h01);
      chk(reg_rdata_out, shadow[i]);
    end
    ext = 3'($urandom);
    rreg(8'h20);
    chk(reg_rdata_out | {7'h00, reg_hit_out}, 8'h00);
    rreg(PIN_INPUT_STATE_ADDR);
    chk(reg_rdata_out, lvl(shadow[0][2:0], shadow[1][2:0], ext));
    wreg(8'h15, 8'hff);
    ext = 3'h0;
    wreg(8'h1e, 8'h05);
    wreg(8'h1f, 8'hfa);
    wreg(8'h1c, 8'h02);
    wreg(8'h1d, 8'hfd);
    wreg(8'h1b, 8'hff);
    ext = 3'h7;
    rreg(8'h1a);
    chk(reg_rdata_out, 8'h05);
    ext = 3'h0;
    rreg(8'h1b);
    chk(reg_rdata_out, 8'h07);
    wreg(8'h1a, 8'h01);
    // Lone sources first, then random sets
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_in) #1 status_src_in = 8'h00;
      @(posedge clk_in) #1 status_src_in = (i < 8) ? 8'h01 << i : 8'($urandom);
      #1 chk(status_rise_event_out, shadow[2] & status_src_in);
    end
    // Drive every pin, then a mid-run reset must release them all
    wreg(PIN_LEVEL_SET_ADDR, 8'hff);
    wreg(PIN_DIRECTION_SET_ADDR, 8'h07);
    chk({2'h0, pin_oe_out, pin_out}, 8'h3f);
    @(posedge clk_in) #1 reset_n_in = 0;
    repeat (2) @(posedge clk_in);
    #1 reset_n_in = 1;
    chk({2'h0, pin_oe_out, pin_out}, 8'h00);
    rreg(PIN_LEVEL_CLEAR_ADDR);
    chk(reg_rdata_out, 8'h00);
    chk({7'h00, reg_hit_out}, 8'h01);
    final_report();
  end
endmodule
